// File: nvmac_pkg.sv
package nvmac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices on the bus
  localparam int         REG_AW     = 4;
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_KEY    = 4'h1;
  localparam logic [3:0] REG_ADR_LO = 4'h2;
  localparam logic [3:0] REG_ADR_HI = 4'h3;
  localparam logic [3:0] REG_DAT_LO = 4'h4;
  localparam logic [3:0] REG_DAT_HI = 4'h5;
  localparam logic [3:0] REG_PTR_LO = 4'h6;
  localparam logic [3:0] REG_PTR_HI = 4'h7;
  localparam logic [3:0] REG_IND    = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Control register bit positions
  localparam int B_RD    = 0;
  localparam int B_WR    = 1;
  localparam int B_WRITE_ALLOW  = 2;
  localparam int B_FREE  = 3;
  localparam int B_REGS  = 4;
  localparam int B_DONE  = 5;
  localparam int B_IRQEN = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Key values and memory geometry
  localparam logic [7:0]  KEY_FIRST   = 8'h55;
  localparam logic [7:0]  KEY_SECOND  = 8'haa;
  localparam int          FLASH_W     = 14;
  localparam int          EE_W        = 8;
  localparam int          FLASH_DEPTH = 4096;
  localparam int          EE_DEPTH    = 256;
  localparam int          ROW_WORDS   = 32;
  localparam logic [4:0]  ROW_LAST    = 5'h1f;
  localparam logic [14:0] USER_TOP    = 15'h07ff;
  localparam logic [14:0] UID_TOP     = 15'h0003;
  localparam logic [14:0] REV_ADR     = 15'h0005;
  localparam logic [14:0] DEV_ADR     = 15'h0006;
  localparam logic [14:0] CFG_FIRST   = 15'h0007;
  localparam logic [14:0] CFG_LAST    = 15'h000a;
  localparam logic [6:0]  EE_REG_HI   = 7'h70;
  localparam logic [7:0]  EE_IND_HI   = 8'hf0;
  localparam logic [9:0]  UID_ROW     = 10'h200;
  localparam logic [13:0] ERASED      = 14'h3fff;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS       = 10;
  localparam int EE_WRITE_NS  = 4000;
  localparam int EE_WRITE_CYC = (EE_WRITE_NS + CLK_NS - 1) / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RD    = 2'b01,
    ST_IND   = 2'b10,
    ST_ERASE = 2'b11
  } nvmac_state_t;

  typedef enum logic [1:0] {
    KS_IDLE   = 2'b00,
    KS_FIRST  = 2'b01,
    KS_SECOND = 2'b10
  } nvmac_key_t;

  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_FLASH = 2'b01,
    SRC_EE    = 2'b10,
    SRC_CONST = 2'b11
  } nvmac_src_t;

endpackage : nvmac_pkg

// File: nvmac_mem.sv
`timescale 1ns/1ps
module nvmac_mem #(
  parameter int W = 14,
  parameter int D = 4096
) (
  input  wire logic                 clk_i,
  input  wire logic                 we_i,
  input  wire logic [$clog2(D)-1:0] waddr_i,
  input  wire logic [W-1:0]         wdata_i,
  input  wire logic [$clog2(D)-1:0] raddr_i,
  output logic      [W-1:0]         rdata_o
);

  if (W < 1 || D < 2) begin : g_chk
    $error("nvmac_mem: bad geometry");
  end

  logic [W-1:0] mem [0:D-1];

  ////////////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port, valid one cycle after address
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end

endmodule : nvmac_mem

// File: nvmac_key.sv
`timescale 1ns/1ps
module nvmac_key (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       acc_i,
  input  wire logic       key_wr_i,
  input  wire logic [7:0] key_data_i,
  output logic            armed_o
);

  nvmac_pkg::nvmac_key_t state_reg;
  nvmac_pkg::nvmac_key_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Every taken access advances or breaks the sequence
  always_comb begin
    state_next = state_reg;
    if (acc_i) begin
      state_next = nvmac_pkg::KS_IDLE;
      if (key_wr_i && key_data_i == nvmac_pkg::KEY_FIRST) begin
        state_next = nvmac_pkg::KS_FIRST;
      end else if (key_wr_i && key_data_i == nvmac_pkg::KEY_SECOND &&
                   state_reg == nvmac_pkg::KS_FIRST) begin
        state_next = nvmac_pkg::KS_SECOND;
      end
    end
  end

  // Sequence state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= nvmac_pkg::KS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Armed only for the access right after both keys
  assign armed_o = (state_reg == nvmac_pkg::KS_SECOND);

endmodule : nvmac_key

// File: nvmac_top.sv
`timescale 1ns/1ps
module nvmac_top #(
  parameter int                  EE_WRITE_CYC = nvmac_pkg::EE_WRITE_CYC,
  parameter logic [13:0]         REV_ID       = 14'h0123,  // Arbitrary value
  parameter logic [13:0]         DEV_ID       = 14'h0456,  // Arbitrary value
  parameter logic [4*14-1:0]     CFG_WORDS    = {4{14'h3fff}}
) (
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RSTN_I,
  input  wire logic [nvmac_pkg::REG_AW-1:0] AVS_ADDRESS_I,
  input  wire logic                         AVS_READ_I,
  input  wire logic                         AVS_WRITE_I,
  input  wire logic [31:0]                  AVS_WRITEDATA_I,
  output logic      [31:0]                  AVS_READDATA_O,
  output logic                              AVS_WAITREQUEST_O,
  input  wire logic                         CODE_PROT_I,
  input  wire logic                         WRITE_PROT_I,
  output logic                              OP_DONE_IRQ_O,
  output logic                              EE_BUSY_O
);

  if (EE_WRITE_CYC < 1 || EE_WRITE_CYC > 65535) begin : g_chk
    $error("nvmac_top: EE_WRITE_CYC out of range");
  end

  localparam int FW = nvmac_pkg::FLASH_W;
  localparam int FA = $clog2(nvmac_pkg::FLASH_DEPTH);
  localparam int EA = $clog2(nvmac_pkg::EE_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   cp_meta_reg;
  logic                   cp_reg;
  logic                   wp_meta_reg;
  logic                   wp_reg;
  nvmac_pkg::nvmac_state_t state_reg;
  logic                   wait_reg;
  logic [31:0]            rdata_reg;
  logic [4:0]             erase_cnt_reg;
  logic [6:0]             row_reg;
  nvmac_pkg::nvmac_src_t  src_reg;
  logic [FW-1:0]          cval_reg;
  logic [7:0]             adr_lo_reg;
  logic [6:0]             adr_hi_reg;
  logic [7:0]             dat_lo_reg;
  logic [5:0]             dat_hi_reg;
  logic [7:0]             ptr_lo_reg;
  logic [7:0]             ptr_hi_reg;
  logic                   rd_reg;
  logic                   wr_reg;
  logic                   write_allow_reg;
  logic                   free_reg;
  logic                   regs_reg;
  logic                   done_reg;
  logic                   irqen_reg;
  logic                   irq_reg;
  logic                   ee_busy_reg;
  logic [15:0]            ee_cnt_reg;
  logic [EA-1:0]          ee_adr_reg;
  logic [7:0]             ee_dat_reg;
  logic                   take;
  logic                   wr_take;
  logic                   ctrl_wr;
  logic                   ind_take;
  logic                   armed;
  logic [31:0]            wd;
  logic [14:0]            adr15;
  logic [15:0]            ptr16;
  nvmac_pkg::nvmac_src_t  d_src;
  logic [FA-1:0]          d_fidx;
  logic [EA-1:0]          d_eidx;
  logic [FW-1:0]          d_cval;
  logic                   trig_ok;
  logic                   start_read;
  logic                   start_ee;
  logic                   start_erase;
  logic                   erase_done;
  logic                   ee_done;
  logic [FW-1:0]          f_rdata;
  logic [7:0]             e_rdata;
  logic [FW-1:0]          rd_val;
  logic [31:0]            reg_rdata;
  logic [FW-1:0]          cfg_arr [0:3];

  ////////////////////////////////////////////////////////////////////////////
  // Protection pins pass two flip-flops
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cp_meta_reg <= 1'b1;
      cp_reg      <= 1'b1;
      wp_meta_reg <= 1'b1;
      wp_reg      <= 1'b1;
    end else begin
      cp_meta_reg <= CODE_PROT_I;
      cp_reg      <= cp_meta_reg;
      wp_meta_reg <= WRITE_PROT_I;
      wp_reg      <= wp_meta_reg;
    end
  end

  // Configuration words as a table
  for (genvar g = 0; g < 4; g++) begin : g_cfg
    assign cfg_arr[g] = CFG_WORDS[g*FW +: FW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  assign wd       = AVS_WRITEDATA_I;
  assign adr15    = {adr_hi_reg, adr_lo_reg};
  assign ptr16    = {ptr_hi_reg, ptr_lo_reg};
  assign take     = (AVS_READ_I | AVS_WRITE_I) & wait_reg &
                    (state_reg == nvmac_pkg::ST_IDLE);
  assign wr_take  = take & AVS_WRITE_I;
  assign ctrl_wr  = wr_take & (AVS_ADDRESS_I == nvmac_pkg::REG_CTRL);
  assign ind_take = take & AVS_READ_I &
                    (AVS_ADDRESS_I == nvmac_pkg::REG_IND);

  // Address map of the selected region
  always_comb begin
    d_src  = nvmac_pkg::SRC_NONE;
    d_fidx = '0;
    d_eidx = '0;
    d_cval = '0;
    if (ind_take) begin
      if (ptr16[15:8] == nvmac_pkg::EE_IND_HI) begin
        d_src  = nvmac_pkg::SRC_EE;
        d_eidx = ptr16[7:0];
      end else if (ptr16[15]) begin
        d_src  = nvmac_pkg::SRC_FLASH;
        d_fidx = {1'b0, ptr16[10:0]};
      end
    end else if (!wd[nvmac_pkg::B_REGS]) begin
      if (adr15 <= nvmac_pkg::USER_TOP) begin
        d_src  = nvmac_pkg::SRC_FLASH;
        d_fidx = {1'b0, adr15[10:0]};
      end
    end else if (adr15 <= nvmac_pkg::UID_TOP) begin
      d_src  = nvmac_pkg::SRC_FLASH;
      d_fidx = {nvmac_pkg::UID_ROW, adr15[1:0]};
    end else if (adr15 == nvmac_pkg::REV_ADR) begin
      d_src  = nvmac_pkg::SRC_CONST;
      d_cval = REV_ID;
    end else if (adr15 == nvmac_pkg::DEV_ADR) begin
      d_src  = nvmac_pkg::SRC_CONST;
      d_cval = DEV_ID;
    end else if (adr15 >= nvmac_pkg::CFG_FIRST &&
                 adr15 <= nvmac_pkg::CFG_LAST) begin
      d_src  = nvmac_pkg::SRC_CONST;
      d_cval = cfg_arr[adr15[1:0] + 2'h1];
    end else if (adr15[14:8] == nvmac_pkg::EE_REG_HI) begin
      d_src  = nvmac_pkg::SRC_EE;
      d_eidx = adr15[7:0];
    end
  end

  // Operation starts from a control write
  assign trig_ok     = ctrl_wr & wd[nvmac_pkg::B_WR] & armed &
                       wd[nvmac_pkg::B_WRITE_ALLOW] & ~cp_reg & ~ee_busy_reg &
                       ~wd[nvmac_pkg::B_RD];
  assign start_read  = ctrl_wr & wd[nvmac_pkg::B_RD] & ~cp_reg;
  assign start_ee    = trig_ok & (d_src == nvmac_pkg::SRC_EE);
  assign start_erase = trig_ok & wd[nvmac_pkg::B_FREE] &
                       (d_src == nvmac_pkg::SRC_FLASH) &
                       ~(~wd[nvmac_pkg::B_REGS] & wp_reg);
  assign erase_done  = (state_reg == nvmac_pkg::ST_ERASE) &
                       (erase_cnt_reg == nvmac_pkg::ROW_LAST);
  assign ee_done     = ee_busy_reg & (ee_cnt_reg == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // Key sequence tracker
  nvmac_key u_key (
    .clk_i      (CORE_CLK_I),
    .rstn_i     (RSTN_I),
    .acc_i      (take),
    .key_wr_i   (wr_take & (AVS_ADDRESS_I == nvmac_pkg::REG_KEY)),
    .key_data_i (wd[7:0]),
    .armed_o    (armed)
  );

  // Program flash with user IDs, erase writes rows to blank
  nvmac_mem #(
    .W (FW),
    .D (nvmac_pkg::FLASH_DEPTH)
  ) u_flash (
    .clk_i   (CORE_CLK_I),
    .we_i    (state_reg == nvmac_pkg::ST_ERASE),
    .waddr_i ({row_reg, erase_cnt_reg}),
    .wdata_i (nvmac_pkg::ERASED),
    .raddr_i (d_fidx),
    .rdata_o (f_rdata)
  );

  // Data EEPROM, byte wide
  nvmac_mem #(
    .W (nvmac_pkg::EE_W),
    .D (nvmac_pkg::EE_DEPTH)
  ) u_ee (
    .clk_i   (CORE_CLK_I),
    .we_i    (ee_done),
    .waddr_i (ee_adr_reg),
    .wdata_i (ee_dat_reg),
    .raddr_i (d_eidx),
    .rdata_o (e_rdata)
  );

  // Value of a completed memory read
  always_comb begin
    case (src_reg)
      nvmac_pkg::SRC_FLASH: rd_val = f_rdata;
      nvmac_pkg::SRC_EE:    rd_val = {6'h00, e_rdata};
      nvmac_pkg::SRC_CONST: rd_val = cval_reg;
      default:              rd_val = '0;
    endcase
  end

  // Register read mux, unmapped words read zero
  always_comb begin
    case (AVS_ADDRESS_I)
      nvmac_pkg::REG_CTRL:   reg_rdata = {25'h0, irqen_reg, done_reg,
                                          regs_reg, free_reg, write_allow_reg,
                                          wr_reg, rd_reg};
      nvmac_pkg::REG_ADR_LO: reg_rdata = {24'h0, adr_lo_reg};
      nvmac_pkg::REG_ADR_HI: reg_rdata = {25'h0, adr_hi_reg};
      nvmac_pkg::REG_DAT_LO: reg_rdata = {24'h0, dat_lo_reg};
      nvmac_pkg::REG_DAT_HI: reg_rdata = {26'h0, dat_hi_reg};
      nvmac_pkg::REG_PTR_LO: reg_rdata = {24'h0, ptr_lo_reg};
      nvmac_pkg::REG_PTR_HI: reg_rdata = {24'h0, ptr_hi_reg};
      default:               reg_rdata = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and stall sequencer
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_reg     <= nvmac_pkg::ST_IDLE;
      wait_reg      <= 1'b1;
      rdata_reg     <= 32'h0;
      erase_cnt_reg <= 5'h00;
      row_reg       <= 7'h00;
      src_reg       <= nvmac_pkg::SRC_NONE;
      cval_reg      <= '0;
    end else begin
      case (state_reg)
        nvmac_pkg::ST_IDLE: begin
          if (!wait_reg) begin
            wait_reg <= 1'b1;
          end else if (take) begin
            src_reg  <= d_src;
            cval_reg <= d_cval;
            if (start_read) begin
              state_reg <= nvmac_pkg::ST_RD;
            end else if (ind_take) begin
              state_reg <= nvmac_pkg::ST_IND;
            end else if (start_erase) begin
              state_reg     <= nvmac_pkg::ST_ERASE;
              erase_cnt_reg <= 5'h00;
              row_reg       <= d_fidx[FA-1:5];
            end else begin
              wait_reg  <= 1'b0;
              rdata_reg <= AVS_READ_I ? reg_rdata : 32'h0;
            end
          end
        end
        nvmac_pkg::ST_RD: begin
          wait_reg  <= 1'b0;
          rdata_reg <= 32'h0;
          state_reg <= nvmac_pkg::ST_IDLE;
        end
        nvmac_pkg::ST_IND: begin
          wait_reg  <= 1'b0;
          rdata_reg <= {18'h0, rd_val};
          state_reg <= nvmac_pkg::ST_IDLE;
        end
        nvmac_pkg::ST_ERASE: begin
          erase_cnt_reg <= erase_cnt_reg + 5'h01;
          if (erase_done) begin
            wait_reg  <= 1'b0;
            rdata_reg <= 32'h0;
            state_reg <= nvmac_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= nvmac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address, pointer and data registers
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      adr_lo_reg <= 8'h00;
      adr_hi_reg <= 7'h00;
      ptr_lo_reg <= 8'h00;
      ptr_hi_reg <= 8'h00;
      dat_lo_reg <= 8'h00;
      dat_hi_reg <= 6'h00;
    end else begin
      if (wr_take) begin
        case (AVS_ADDRESS_I)
          nvmac_pkg::REG_ADR_LO: adr_lo_reg <= wd[7:0];
          nvmac_pkg::REG_ADR_HI: adr_hi_reg <= wd[6:0];
          nvmac_pkg::REG_PTR_LO: ptr_lo_reg <= wd[7:0];
          nvmac_pkg::REG_PTR_HI: ptr_hi_reg <= wd[7:0];
          nvmac_pkg::REG_DAT_LO: dat_lo_reg <= wd[7:0];
          nvmac_pkg::REG_DAT_HI: dat_hi_reg <= wd[5:0];
          default: ;
        endcase
      end
      if (state_reg == nvmac_pkg::ST_RD) begin
        dat_lo_reg <= rd_val[7:0];
        dat_hi_reg <= rd_val[FW-1:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; completion set wins over software clear
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      write_allow_reg  <= 1'b0;
      free_reg  <= 1'b0;
      regs_reg  <= 1'b0;
      done_reg  <= 1'b0;
      irqen_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        write_allow_reg  <= wd[nvmac_pkg::B_WRITE_ALLOW];
        free_reg  <= wd[nvmac_pkg::B_FREE];
        regs_reg  <= wd[nvmac_pkg::B_REGS];
        irqen_reg <= wd[nvmac_pkg::B_IRQEN];
      end
      if (start_read) begin
        rd_reg <= 1'b1;
      end else if (state_reg == nvmac_pkg::ST_RD) begin
        rd_reg <= 1'b0;
      end
      // Plain software writes never move the trigger
      if (start_ee || start_erase) begin
        wr_reg <= 1'b1;
      end else if (ee_done || erase_done) begin
        wr_reg <= 1'b0;
      end
      if (ee_done || erase_done) begin
        done_reg <= 1'b1;
      end else if (ctrl_wr && !wd[nvmac_pkg::B_DONE]) begin
        done_reg <= 1'b0;
      end
      irq_reg <= done_reg & irqen_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Background EEPROM word write timer
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ee_busy_reg <= 1'b0;
      ee_cnt_reg  <= 16'h0000;
      ee_adr_reg  <= '0;
      ee_dat_reg  <= 8'h00;
    end else if (start_ee) begin
      ee_busy_reg <= 1'b1;
      ee_cnt_reg  <= 16'(EE_WRITE_CYC - 1);
      ee_adr_reg  <= d_eidx;
      ee_dat_reg  <= dat_lo_reg;
    end else if (ee_done) begin
      ee_busy_reg <= 1'b0;
    end else if (ee_busy_reg) begin
      ee_cnt_reg <= ee_cnt_reg - 16'h0001;
    end
  end

  // Outputs straight from flip-flops
  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign OP_DONE_IRQ_O     = irq_reg;
  assign EE_BUSY_O         = ee_busy_reg;

endmodule : nvmac_top

// File: nvmac_sva.sv
`timescale 1ns/1ps
module nvmac_sva (
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        CODE_PROT_I,
  input wire logic        EE_BUSY_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  ////////////////////////////////////////////////////////////////////////////
  // Answer timing on the bus
  chk_wait_pulse: assert property (
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O) else $error("answer held too long");
  chk_idle_quiet: assert property (
    !AVS_READ_I && !AVS_WRITE_I |=> AVS_WAITREQUEST_O) else $error("answer without request");
  chk_ind_stall: assert property (
    $rose(AVS_READ_I) && AVS_ADDRESS_I == nvmac_pkg::REG_IND
    |=> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("indirect read timing");
  chk_rd_stall: assert property (
    $rose(AVS_WRITE_I) && AVS_ADDRESS_I == nvmac_pkg::REG_CTRL && !CODE_PROT_I
    && AVS_WRITEDATA_I[1:0] == 2'b01
    |=> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("read trigger timing");
  chk_key_answer: assert property (
    $rose(AVS_WRITE_I) && AVS_ADDRESS_I == nvmac_pkg::REG_KEY
    |=> !AVS_WAITREQUEST_O) else $error("key write not answered");
  ////////////////////////////////////////////////////////////////////////////
  // Operation start and read contents
  chk_busy_cause: assert property (
    $rose(EE_BUSY_O) |-> $past(AVS_WRITE_I) && $past(AVS_WRITEDATA_I[2:1]) == 2'b11)
    else $error("write started without allow");
  chk_rd_clear: assert property (
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == nvmac_pkg::REG_CTRL
    |-> !AVS_READDATA_O[0]) else $error("read trigger not cleared");
  chk_unmapped_zero: assert property (
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I > nvmac_pkg::REG_IND
    |-> AVS_READDATA_O == 32'h0) else $error("unmapped word not zero");
  // Main scenarios reached
  cov_ee_done: cover property ($fell(EE_BUSY_O));
  cov_ind_read: cover property ($rose(AVS_READ_I) && AVS_ADDRESS_I == nvmac_pkg::REG_IND);
  cov_long_stall: cover property ((AVS_WRITE_I && AVS_WAITREQUEST_O) [*8]);
endmodule : nvmac_sva
bind nvmac_top nvmac_sva u_sva (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .CODE_PROT_I(CODE_PROT_I), .EE_BUSY_O(EE_BUSY_O));

// File: nvmac_core_model.sv
`timescale 1ns/1ps
module nvmac_core_model (
  input  wire logic        clk_i,
  input  wire logic        waitreq_i,
  input  wire logic [31:0] rdata_i,
  output logic      [3:0]  addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o
);
  int stall;
  // Idle bus at time zero
  initial begin
    addr_o  = 4'hf;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One transfer, held until waitrequest samples low, then released
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    rd_o    <= !w;
    wr_o    <= w;
    addr_o  <= a;
    wdata_o <= d;
    stall = 0;
    do begin
      @(posedge clk_i);
      stall++;
    end while (waitreq_i !== 1'b0);
    q = rdata_i;
    rd_o    <= 1'b0;
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : xfer
  // Plain write and read
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Key pair back to back, no interrupt or access in between
  task automatic keys;
    wr(nvmac_pkg::REG_KEY, 32'h55);
    wr(nvmac_pkg::REG_KEY, 32'haa);
  endtask : keys
  // Target address, keys, then the control write
  task automatic launch(input logic [14:0] a, input logic [31:0] ctl);
    wr(nvmac_pkg::REG_ADR_LO, {24'h0, a[7:0]});
    wr(nvmac_pkg::REG_ADR_HI, {25'h0, a[14:8]});
    keys();
    wr(nvmac_pkg::REG_CTRL, ctl);
  endtask : launch
endmodule : nvmac_core_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        cp   = 1'b0;
  logic        wp   = 1'b0;
  logic        rd, wr, wt, irq, busy;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, q;
  int          err_total       = 0;
  int          samples_checked = 0;
  // Clock, design and core model
  initial forever #5 clk = ~clk;
  nvmac_top #(.EE_WRITE_CYC(20), .REV_ID(14'h1234)) dut ( // Revision id arbitrary
    .CORE_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wt),
    .CODE_PROT_I(cp), .WRITE_PROT_I(wp), .OP_DONE_IRQ_O(irq), .EE_BUSY_O(busy));
  nvmac_core_model m (.clk_i(clk), .waitreq_i(wt), .rdata_i(rdat), .addr_o(adr),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Optional read trigger, then the data pair into q
  task automatic fetch(input logic [14:0] a, input logic [31:0] ctl);
    logic [31:0] lo;
    if (ctl != 32'h0) begin
      m.wr(nvmac_pkg::REG_ADR_LO, {24'h0, a[7:0]});
      m.wr(nvmac_pkg::REG_ADR_HI, {25'h0, a[14:8]});
      m.wr(nvmac_pkg::REG_CTRL, ctl);
    end
    m.rd(nvmac_pkg::REG_DAT_LO, lo);
    m.rd(nvmac_pkg::REG_DAT_HI, q);
    q = {18'h0, q[5:0], lo[7:0]};
  endtask : fetch
  // Read path: identity, config, hold, protection, unmapped word
  task automatic t_read;
    fetch(15'h0005, 32'h11);
    chk(q, 32'h1234);
    m.rd(nvmac_pkg::REG_CTRL, q);
    chk(q & 32'h1, 32'h0);
    fetch(15'h000a, 32'h11);
    chk(q, 32'h3fff);
    m.wr(nvmac_pkg::REG_DAT_LO, 32'h3c);
    @(posedge clk);
    cp <= 1'b1;
    repeat (3) @(posedge clk);
    fetch(15'h0005, 32'h11);
    chk(q, 32'h3f3c);
    @(posedge clk);
    cp <= 1'b0;
    m.rd(4'hc, q);
    chk(q, 32'h0);
    $display("read path test finished");
  endtask : t_read
  // Background write, ignored clear, completion, readback both ways
  task automatic t_ee;
    int n;
    m.wr(nvmac_pkg::REG_DAT_LO, 32'h5a);
    m.launch(15'h7010, 32'h16);
    chk(32'(m.stall), 32'h2);
    m.wr(nvmac_pkg::REG_CTRL, 32'h14);
    m.rd(nvmac_pkg::REG_CTRL, q);
    chk(q & 32'h2, 32'h2);
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
    m.rd(nvmac_pkg::REG_CTRL, q);
    chk(q & 32'h26, 32'h24);
    chk({31'h0, irq}, 32'h0);
    m.wr(nvmac_pkg::REG_PTR_LO, 32'h10);
    m.wr(nvmac_pkg::REG_PTR_HI, 32'hf0);
    m.wr(nvmac_pkg::REG_IND, 32'h0);
    m.rd(nvmac_pkg::REG_IND, q);
    chk(q, 32'h5a);
    fetch(15'h7010, 32'h11);
    chk(q, 32'h5a);
    $display("eeprom write test finished");
  endtask : t_ee
  // Key pair interrupted by a read, missing allow, protected row: nothing starts
  task automatic t_refuse;
    m.wr(nvmac_pkg::REG_KEY, 32'h55);
    m.rd(nvmac_pkg::REG_ADR_LO, q);
    m.wr(nvmac_pkg::REG_KEY, 32'haa);
    m.wr(nvmac_pkg::REG_CTRL, 32'h16);
    chk({31'h0, busy}, 32'h0);
    m.keys();
    m.wr(nvmac_pkg::REG_CTRL, 32'h12);
    chk({31'h0, busy}, 32'h0);
    @(posedge clk);
    wp <= 1'b1;
    repeat (3) @(posedge clk);
    m.launch(15'h0040, 32'h4e);
    m.rd(nvmac_pkg::REG_CTRL, q);
    chk(q & 32'h22, 32'h0);
    @(posedge clk);
    wp <= 1'b0;
    $display("refusal test finished");
  endtask : t_refuse
  // Row erase: stall length, flag, interrupt, blank row, allow kept
  task automatic t_erase;
    repeat (3) @(posedge clk);
    m.launch(15'h0040, 32'h4e);
    chk(32'(m.stall), 32'(nvmac_pkg::ROW_WORDS + 2));
    m.rd(nvmac_pkg::REG_CTRL, q);
    chk(q & 32'h26, 32'h24);
    chk({31'h0, irq}, 32'h1);
    fetch(15'h005f, 32'h01);
    chk(q, 32'h3fff);
    m.wr(nvmac_pkg::REG_PTR_LO, 32'h5f);
    m.wr(nvmac_pkg::REG_PTR_HI, 32'h80);
    m.rd(nvmac_pkg::REG_IND, q);
    chk(q, 32'h3fff);
    $display("row erase test finished");
  endtask : t_erase
  // Verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_read();
    t_ee();
    t_refuse();
    t_erase();
    conclude();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule : testbench
